// File: rtl/banked_data_memory_status.sv
// Banked data memory with special registers and the core flag register.
// Assumes one core operation per enabled cycle, synchronous inputs
// and reset events as one-cycle pulses.
//
// Notes on behaviour
// - Direct accesses pick one of four banks from the two-bit bank field.
// - Flag-updating writes to the flag register keep hardware flag values.
// - Software writes never change the expiry and sleep flags.
// - Clearing the flag register leaves 000u u1uu.
// - Expiry flag sets on power-up, watchdog clear or sleep; clears on time-out.
// - Add and subtract set nibble carry from the carry out of result bit 3.
// - Subtract adds the two's complement; carries then mean no borrow.
// - Unimplemented locations read zero and ignore writes.
// - Location 00h of every bank reaches the pointer-addressed location.
// - Non-power resets keep the port compare latch; change flag re-sets on mismatch.
// - External and watchdog resets are non-power-up resets with their own values.
`timescale 1ns/1ps
`default_nettype none

module banked_data_memory_status #(
    parameter int PORT_WIDTH = 6
) (
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    input  wire logic                  clock_enable,
    input  wire logic                  op_valid,
    input  wire logic [3:0]            op_code,
    input  wire logic [6:0]            file_addr,
    input  wire logic                  dest_file,
    input  wire logic [7:0]            w_operand,
    input  wire logic [2:0]            bit_index,
    input  wire logic                  watchdog_clear_instr,
    input  wire logic                  sleep_instr,
    input  wire logic                  watchdog_timeout,
    input  wire logic                  external_reset_pin,
    input  wire logic                  watchdog_reset,
    input  wire logic                  brownout_reset,
    input  wire logic [PORT_WIDTH-1:0] port_a_in,
    input  wire logic [PORT_WIDTH-1:0] port_c_in,
    output logic [7:0]                 result_data,
    output logic                       result_valid,
    output logic [7:0]                 core_flags,
    output logic [PORT_WIDTH-1:0]      port_a_latch,
    output logic [PORT_WIDTH-1:0]      port_c_latch,
    output logic                       port_change_flag
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic reset_meta_n;
    logic rst_n;

    // Two stages keep release clear of the clock edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reset_meta_n <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            reset_meta_n <= 1'b1;
            rst_n        <= reset_meta_n;
        end
    end

    // ------------------------------------------------------------------
    // Address folding
    // ------------------------------------------------------------------
    // Folds banks 2/3 low registers onto banks 0/1 and the common top to bank 0
    function automatic logic [8:0] fold_addr(input logic [8:0] raw);
        logic [8:0] folded;
        folded = raw;
        if (raw[6:0] >= data_memory_pkg::COMMON_FIRST) begin
            folded = {2'b00, raw[6:0]};
        end else if (raw[8] && raw[6:0] <= data_memory_pkg::SHARED_LOW_LAST) begin
            folded = {1'b0, raw[7:0]};
        end
        return folded;
    endfunction : fold_addr

    logic [7:0]           pointer;
    logic [8:0]           direct_addr;
    logic [8:0]           indirect_addr;
    logic                 via_pointer;
    logic                 pointer_void;
    logic [8:0]           eff_addr;
    logic                 low_banks;
    logic [6:0]           eff_low;

    assign direct_addr   = fold_addr({core_flags[data_memory_pkg::BANK_HI_BIT:
                                                 data_memory_pkg::BANK_LO_BIT],
                                      file_addr});
    assign indirect_addr = fold_addr({core_flags[data_memory_pkg::INDIRECT_BANK_BIT],
                                      pointer});
    assign via_pointer   = direct_addr[6:0] == data_memory_pkg::INDIRECT_OFFSET;
    // Pointer aimed back at location 00h reaches nothing
    assign pointer_void  = via_pointer &&
                           indirect_addr[6:0] == data_memory_pkg::INDIRECT_OFFSET;
    assign eff_addr      = via_pointer ? indirect_addr : direct_addr;
    assign low_banks     = !eff_addr[8] && !pointer_void;
    assign eff_low       = eff_addr[6:0];

    // ------------------------------------------------------------------
    // Location decode
    // ------------------------------------------------------------------
    logic                                 flags_hit;
    logic [data_memory_pkg::SFR_COUNT-1:0] slot_hit;
    logic                                 gpr_hit;
    logic [6:0]                           gpr_index;

    // Flag register, pointer, pcl, pc_upper_latch and interrupt_control are single copies
    assign flags_hit = low_banks && eff_low == data_memory_pkg::CORE_FLAGS_OFFSET;
    assign gpr_hit   = low_banks && eff_low >= data_memory_pkg::GPR_FIRST &&
                       (!eff_addr[7] || eff_low <= data_memory_pkg::GPR_BANK1_LAST);
    assign gpr_index = eff_addr[7]
                     ? 7'(eff_low - data_memory_pkg::GPR_FIRST
                          + data_memory_pkg::GPR_BANK1_BASE)
                     : 7'(eff_low - data_memory_pkg::GPR_FIRST);

    // ------------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------------
    data_memory_pkg::op_type op;
    logic                    op_run;
    logic                    nonpower_reset;
    logic                    writes_file;

    assign op             = data_memory_pkg::op_type'(op_code);
    // Reset events abort any operation in the same cycle
    assign nonpower_reset = external_reset_pin || watchdog_reset;
    assign op_run         = op_valid && !nonpower_reset && !brownout_reset;
    assign writes_file    = op_run && (dest_file ||
                            op == data_memory_pkg::OP_MOVE_W ||
                            op == data_memory_pkg::OP_CLEAR ||
                            op == data_memory_pkg::OP_BIT_CLR ||
                            op == data_memory_pkg::OP_BIT_SET);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]                                sfr_value [data_memory_pkg::SFR_COUNT];
    logic [7:0]                                gpr_mem   [data_memory_pkg::GPR_BYTES];
    logic [7:0]                                next_result;
    logic [data_memory_pkg::SFR_COUNT-1:0][7:0] slot_read;
    logic [7:0]                                sfr_read;
    logic [7:0]                                file_value;

    // One flop group per special register
    for (genvar k = 0; k < data_memory_pkg::SFR_COUNT; k++) begin : g_sfr
        logic slot_write;
        logic local_hit;
        assign local_hit  = low_banks &&
                            eff_low == data_memory_pkg::SFR_OFFSET[k][6:0] &&
                            (!eff_addr[7] || data_memory_pkg::SFR_DUPLICATED[k]);
        assign slot_hit[k] = local_hit;
        assign slot_write  = writes_file && local_hit;

        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                sfr_value[k] <= data_memory_pkg::SFR_RESET[k];
            end else if (clock_enable) begin
                if (nonpower_reset || brownout_reset) begin
                    sfr_value[k] <= data_memory_pkg::SFR_RESET[k];
                end else if (slot_write) begin
                    sfr_value[k] <= next_result & data_memory_pkg::SFR_MASK[k];
                end
            end
        end

        // Ports read pins, the rest stored bits
        if (k == data_memory_pkg::SLOT_PORT_A) begin : g_pa
            assign slot_read[k] = local_hit ? 8'(port_a_in) : 8'h00;
        end else if (k == data_memory_pkg::SLOT_PORT_C) begin : g_pc
            assign slot_read[k] = local_hit ? 8'(port_c_in) : 8'h00;
        end else if (k == data_memory_pkg::SLOT_INTERRUPT) begin : g_ic
            assign slot_read[k] = local_hit
                                ? (sfr_value[k] | {7'h00, port_change_flag}) : 8'h00;
        end else begin : g_plain
            assign slot_read[k] = local_hit ? sfr_value[k] : 8'h00;
        end
    end

    // OR of one-hot selections; unmapped locations give zero
    always_comb begin
        sfr_read = 8'h00;
        for (int i = 0; i < data_memory_pkg::SFR_COUNT; i++) begin
            sfr_read = sfr_read | slot_read[i];
        end
    end

    assign file_value = flags_hit ? core_flags :
                        gpr_hit   ? gpr_mem[gpr_index] :
                        sfr_read;

    // General purpose bytes carry no reset
    always_ff @(posedge clock) begin
        if (clock_enable && writes_file && gpr_hit) begin
            gpr_mem[gpr_index] <= next_result;
        end
    end

    assign pointer      = sfr_value[2];
    assign port_a_latch = sfr_value[data_memory_pkg::SLOT_PORT_A][PORT_WIDTH-1:0];
    assign port_c_latch = sfr_value[data_memory_pkg::SLOT_PORT_C][PORT_WIDTH-1:0];

    // ------------------------------------------------------------------
    // Arithmetic and flag results
    // ------------------------------------------------------------------
    logic       subtracting;
    logic [7:0] addend;
    logic       carry_in;
    logic [8:0] full_sum;
    logic [4:0] nibble_sum;
    logic [7:0] bit_mask;
    logic       update_null;
    logic       update_nibble;
    logic       update_wrap;
    logic       new_wrap;

    // Subtraction adds the inverted operand plus one
    assign subtracting = op == data_memory_pkg::OP_SUB;
    assign addend      = subtracting ? ~w_operand : w_operand;
    assign carry_in    = subtracting;
    assign full_sum    = {1'b0, file_value} + {1'b0, addend} + {8'h00, carry_in};
    assign nibble_sum  = {1'b0, file_value[3:0]} + {1'b0, addend[3:0]}
                       + {4'h0, carry_in};
    assign bit_mask    = 8'h01 << bit_index;

    always_comb begin
        case (op)
            data_memory_pkg::OP_MOVE_W:    next_result = w_operand;
            data_memory_pkg::OP_READ:      next_result = file_value;
            data_memory_pkg::OP_ADD:       next_result = full_sum[7:0];
            data_memory_pkg::OP_SUB:       next_result = full_sum[7:0];
            data_memory_pkg::OP_ROT_RIGHT: next_result = {core_flags[data_memory_pkg::WRAP_BIT],
                                                          file_value[7:1]};
            data_memory_pkg::OP_ROT_LEFT:  next_result = {file_value[6:0],
                                                          core_flags[data_memory_pkg::WRAP_BIT]};
            data_memory_pkg::OP_CLEAR:     next_result = 8'h00;
            data_memory_pkg::OP_SWAP:      next_result = {file_value[3:0], file_value[7:4]};
            data_memory_pkg::OP_BIT_CLR:   next_result = file_value & ~bit_mask;
            data_memory_pkg::OP_BIT_SET:   next_result = file_value | bit_mask;
            default:                       next_result = file_value;
        endcase
    end

    // Which flags each operation drives; bit, swap and move touch none
    assign update_null   = op_run && (op == data_memory_pkg::OP_READ ||
                           op == data_memory_pkg::OP_ADD || subtracting ||
                           op == data_memory_pkg::OP_CLEAR);
    assign update_nibble = op_run && (op == data_memory_pkg::OP_ADD || subtracting);
    assign update_wrap   = op_run && (op == data_memory_pkg::OP_ADD || subtracting ||
                           op == data_memory_pkg::OP_ROT_RIGHT ||
                           op == data_memory_pkg::OP_ROT_LEFT);
    assign new_wrap      = op == data_memory_pkg::OP_ROT_RIGHT ? file_value[0] :
                           op == data_memory_pkg::OP_ROT_LEFT  ? file_value[7] :
                           full_sum[8];

    // ------------------------------------------------------------------
    // Core flag register
    // ------------------------------------------------------------------
    logic [7:0] written_flags;
    logic [7:0] next_flags;
    logic       flags_write;
    logic       expiry_next;
    logic       sleep_next;

    assign flags_write = writes_file && flags_hit;

    // Written bits first; hardware flags override afterwards
    assign written_flags = {next_result[7:5],
                            core_flags[data_memory_pkg::EXPIRY_BIT],
                            core_flags[data_memory_pkg::SLEEP_BIT],
                            (update_null || update_wrap) ? core_flags[2:0] : next_result[2:0]};

    // Time-out beats a same-cycle watchdog clear
    assign expiry_next = (watchdog_timeout || watchdog_reset) ? 1'b0 :
                         (watchdog_clear_instr || sleep_instr) ? 1'b1 :
                         core_flags[data_memory_pkg::EXPIRY_BIT];
    assign sleep_next  = sleep_instr          ? 1'b0 :
                         watchdog_clear_instr ? 1'b1 :
                         core_flags[data_memory_pkg::SLEEP_BIT];

    always_comb begin
        next_flags = flags_write ? written_flags : core_flags;
        if (update_null) begin
            next_flags[data_memory_pkg::NULL_BIT] = next_result == 8'h00;
        end
        if (update_nibble) begin
            next_flags[data_memory_pkg::NIBBLE_BIT] = nibble_sum[4];
        end
        if (update_wrap) begin
            next_flags[data_memory_pkg::WRAP_BIT] = new_wrap;
        end
        next_flags[data_memory_pkg::EXPIRY_BIT] = expiry_next;
        next_flags[data_memory_pkg::SLEEP_BIT]  = sleep_next;
        if (nonpower_reset) begin
            // Bank bits clear, arithmetic flags kept
            next_flags[7:5] = 3'b000;
        end
        if (brownout_reset) begin
            next_flags = data_memory_pkg::CORE_FLAGS_RESET;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_flags <= data_memory_pkg::CORE_FLAGS_RESET;
        end else if (clock_enable) begin
            core_flags <= next_flags;
        end
    end

    // ------------------------------------------------------------------
    // Port change detection
    // ------------------------------------------------------------------
    logic [PORT_WIDTH-1:0] compare_latch;
    logic                  port_mismatch;
    logic                  port_a_read;
    logic                  change_write;

    assign port_a_read   = op_run && slot_hit[data_memory_pkg::SLOT_PORT_A];
    assign port_mismatch = port_a_in != compare_latch;
    assign change_write  = writes_file && slot_hit[data_memory_pkg::SLOT_INTERRUPT];

    // Latch survives non-power resets
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            compare_latch <= '0;
        end else if (clock_enable) begin
            if (brownout_reset) begin
                compare_latch <= '0;
            end else if (port_a_read) begin
                compare_latch <= port_a_in;
            end
        end
    end

    // A mismatch wins over a software clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port_change_flag <= 1'b0;
        end else if (clock_enable) begin
            if (brownout_reset) begin
                port_change_flag <= 1'b0;
            end else if (nonpower_reset) begin
                port_change_flag <= port_mismatch;
            end else if (port_mismatch) begin
                port_change_flag <= 1'b1;
            end else if (change_write) begin
                port_change_flag <= next_result[data_memory_pkg::PORT_CHANGE_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Result to the core
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_data  <= 8'h00;
            result_valid <= 1'b0;
        end else if (clock_enable) begin
            result_valid <= op_run;
            if (op_run) begin
                result_data <= next_result;
            end
        end
    end

endmodule : banked_data_memory_status

`default_nettype wire

// File: rtl/data_memory_pkg.sv
// Constants for the banked data memory and core flag register.
// Assumes one 25 MHz clock and one core operation per enabled cycle.
package data_memory_pkg;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [6:0] INDIRECT_OFFSET   = 7'h00;
    localparam logic [6:0] CORE_FLAGS_OFFSET = 7'h03;
    localparam logic [6:0] SHARED_LOW_LAST   = 7'h0b; // Banks 2/3 fold onto 0/1
    localparam logic [6:0] COMMON_FIRST      = 7'h70; // Top sixteen bytes shared
    localparam logic [6:0] GPR_FIRST         = 7'h20;
    localparam logic [6:0] GPR_BANK1_LAST    = 7'h3f;
    localparam logic [6:0] GPR_BANK1_BASE    = 7'h60; // Bank 1 bytes after bank 0
    localparam int         GPR_BYTES         = 128;

    // ------------------------------------------------------------------
    // Core flag register fields and reset values
    // ------------------------------------------------------------------
    localparam int INDIRECT_BANK_BIT = 7;
    localparam int BANK_HI_BIT       = 6;
    localparam int BANK_LO_BIT       = 5;
    localparam int EXPIRY_BIT        = 4;
    localparam int SLEEP_BIT         = 3;
    localparam int NULL_BIT          = 2;
    localparam int NIBBLE_BIT        = 1;
    localparam int WRAP_BIT          = 0;
    localparam logic [7:0] CORE_FLAGS_RESET = 8'h18;
    localparam int         PORT_CHANGE_BIT  = 0;

    // ------------------------------------------------------------------
    // Bank 0 special registers: slot order is index order, slot 0 first
    // ------------------------------------------------------------------
    localparam int SFR_COUNT = 14;
    localparam int SLOT_PORT_A = 3;
    localparam int SLOT_PORT_C = 4;
    localparam int SLOT_INTERRUPT = 6;
    // timer0, pcl, pointer, port a, port c, pc_upper_latch, interrupt_control, peripheral_irq_flags,
    // timer1_count_low, timer1_count_high, timer1_control, watchdog, comparator main, comparator aux
    localparam logic [SFR_COUNT-1:0][7:0] SFR_OFFSET = {
        8'h1a, 8'h19, 8'h18, 8'h10, 8'h0f, 8'h0e, 8'h0c,
        8'h0b, 8'h0a, 8'h07, 8'h05, 8'h04, 8'h02, 8'h01};
    localparam logic [SFR_COUNT-1:0][7:0] SFR_RESET = {
        8'h02, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // Implemented bits; the port change bit of interrupt_control lives apart
    localparam logic [SFR_COUNT-1:0][7:0] SFR_MASK = {
        8'h03, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hfd,
        8'hfe, 8'h1f, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff};
    // Slots mirrored at the same bank 1 offset
    localparam logic [SFR_COUNT-1:0] SFR_DUPLICATED = 14'b00000001100110;

    // ------------------------------------------------------------------
    // Operations offered by the core
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_MOVE_W    = 4'b0000, // move_w_to_file_instr, no flags
        OP_READ      = 4'b0001, // Pass file value, updates null flag
        OP_ADD       = 4'b0010, // File plus W
        OP_SUB       = 4'b0011, // File minus W
        OP_ROT_RIGHT = 4'b0100,
        OP_ROT_LEFT  = 4'b0101,
        OP_CLEAR     = 4'b0110, // clear_file_instr
        OP_SWAP      = 4'b0111, // nibble_swap_instr, no flags
        OP_BIT_CLR   = 4'b1000, // bit_clear_instr, no flags
        OP_BIT_SET   = 4'b1001  // bit_set_instr, no flags
    } op_type;

endpackage : data_memory_pkg

// File: verification/banked_data_memory_status_asserts.sv
// Checker on the top's ports.
// Assumes one clock, reset by arst_n.
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_status_asserts (
    input wire logic       clock, arst_n, clock_enable, op_valid,
    input wire logic       watchdog_clear_instr, sleep_instr, watchdog_timeout,
    input wire logic       external_reset_pin, watchdog_reset, brownout_reset,
    input wire logic [3:0] op_code,
    input wire logic [6:0] file_addr,
    input wire logic [7:0] result_data, core_flags
);
    // ----------
    // Qualifiers: reset pulses discard ops; calm also keeps them out of event checks
    // ----------
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire logic calm = clock_enable && !external_reset_pin && !watchdog_reset
                      && !brownout_reset;
    wire logic take = calm && op_valid;
    wire logic flg = take && file_addr == 7'h03 && !watchdog_clear_instr
                     && !sleep_instr && !watchdog_timeout;
    AST_TO_PD_LOCKED: assert property (flg |=> $stable(core_flags[4:3]))
        else $error("Reset flags written");
    AST_CLEAR_FLAGS:
        assert property (flg && op_code == 4'h6 |=> core_flags[7:5] == 3'h0
            && core_flags[2] && $stable(core_flags[1:0])) else $error("Bad clear");
    AST_TIMEOUT: assert property (calm && watchdog_timeout |=> !core_flags[4])
        else $error("Expiry kept");
    AST_WDT_CLEAR:
        assert property (calm && watchdog_clear_instr && !watchdog_timeout && !sleep_instr
            |=> core_flags[4:3] == 2'b11) else $error("Bad watchdog clear");
    AST_SLEEP:
        assert property (calm && sleep_instr && !watchdog_timeout && !watchdog_clear_instr
            |=> core_flags[4:3] == 2'b10) else $error("Sleep flags wrong");
    AST_WDT_RESET:
        assert property (clock_enable && watchdog_reset && !brownout_reset
            |=> core_flags[7:4] == 4'h0 && $stable(core_flags[3])) else $error("Bad reset");
    AST_BROWNOUT: assert property (clock_enable && brownout_reset |=> core_flags == 8'h18)
        else $error("Bad brown-out");
    AST_UNIMPL_ZERO:
        assert property (take && op_code == 4'h1 && file_addr == 7'h06
            |=> result_data == 8'h00) else $error("Unimplemented not zero");
    // Main scenarios reached
    COV_SUB: cover property (take && op_code == 4'h3);
    COV_INDIRECT: cover property (take && file_addr == 7'h00);
    COV_WDT_RESET: cover property (clock_enable && watchdog_reset);
endmodule : banked_data_memory_status_asserts
bind banked_data_memory_status banked_data_memory_status_asserts chk (.*);
`default_nettype wire

// File: verification/core_model.sv
// Core model: one data-memory operation at a time.
// Assumes serial calls of issue.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic  clock,
    output logic       op_valid = 1'b0,
    output logic [3:0] op_code = 4'h1,
    output logic [6:0] file_addr = 7'h00,
    output logic       dest_file = 1'b0,
    output logic [7:0] w_operand = 8'h00,
    output logic [2:0] bit_index = 3'h0
);
    // Held from after an edge to the taking edge
    task automatic issue(input logic [3:0] op, input logic [6:0] a, input logic d,
                         input logic [7:0] w);
        @(posedge clock);
        op_valid <= 1'b1;
        op_code <= op;
        file_addr <= a;
        dest_file <= d;
        w_operand <= w;
        bit_index <= w[2:0];
        @(posedge clock);
        op_valid <= 1'b0;
    endtask : issue
endmodule : core_model
`default_nettype wire

// File: verification/test_banked_data_memory_status.sv
// Bench: corner and random operations.
// Assumes core model and checker alongside.
`timescale 1ns/1ps
`default_nettype none
module test_banked_data_memory_status;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic [5:0]  ev = 6'h00;
    logic [5:0]  port_a_in = 6'h00;
    logic        op_valid, dest_file, result_valid, port_change_flag;
    logic [3:0]  op_code, op;
    logic [6:0]  file_addr;
    logic [2:0]  bit_index, fl;
    logic [7:0]  w_operand, result_data, core_flags, v, w;
    logic [10:0] m;
    logic [7:0]  evt [7] = '{8'h0a, 8'h10, 8'h07, 8'h11, 8'h21, 8'h41, 8'h83};
    int          bad_count = 0;
    int          check_count = 0;
    // Events by ev bit: clear, sleep, time-out, pin, watchdog, brown-out
    always #20 clock = ~clock;
    core_model core (.*);
    banked_data_memory_status dut (.*, .clock_enable(1'b1), .port_c_in(6'h00),
        .port_a_latch(), .port_c_latch(), .watchdog_clear_instr(ev[0]),
        .sleep_instr(ev[1]), .watchdog_timeout(ev[2]), .external_reset_pin(ev[3]),
        .watchdog_reset(ev[4]), .brownout_reset(ev[5]));
    task automatic check(input string n, input logic [7:0] e, s);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        core.issue(4'h1, a, 1'b0, 8'h00);
        #1;
        check("read", e, result_data);
        check("valid", 8'h01, 8'(result_valid));
    endtask : rd
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        core.issue(4'h0, a, 1'b1, d);
    endtask : wr
    // Result, zero, nibble, carry; carry 1 = no borrow
    function automatic logic [10:0] model(input logic [3:0] c, input logic [7:0] a, b,
                                          input logic [2:0] f);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, c == 4'h3 ? ~b : b} + {8'h00, c == 4'h3};
        n = {1'b0, a[3:0]} + {1'b0, c == 4'h3 ? ~b[3:0] : b[3:0]} + {4'h0, c == 4'h3};
        if (c == 4'h4) return {f[0], a[7:1], f[2:1], a[0]};
        if (c == 4'h5) return {a[6:0], f[0], f[2:1], a[7]};
        return {s[7:0], s[7:0] == 8'h00, n[4], s[8]};
    endfunction : model
    task automatic final_report;
        $display("Checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        #100us;
        bad_count++;
        final_report();
    end
    initial begin
        void'($urandom(26914));
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        check("flags", 8'h18, core_flags);
        for (int i = 0; i < 14; i++)
            if (i != 3 && i != 4)
                rd(data_memory_pkg::SFR_OFFSET[i][6:0], data_memory_pkg::SFR_RESET[i]);
        v = 8'($urandom);
        wr(7'h25, v);
        wr(7'h7a, v ^ 8'h5a);
        wr(7'h06, 8'hff);
        wr(7'h03, 8'h20);
        wr(7'h25, ~v);
        for (int b = 0; b < 4; b++) begin
            wr(7'h03, {1'b0, 2'(b), 5'h00});
            rd(7'h25, b == 0 ? v : b == 1 ? ~v : 8'h00);
            rd(7'h7a, v ^ 8'h5a);
            rd(7'h06, 8'h00);
        end
        wr(7'h04, 8'ha5);
        wr(7'h03, 8'h00);
        rd(7'h00, ~v);
        wr(7'h03, 8'h80);
        rd(7'h00, 8'h00);
        wr(7'h03, 8'h00);
        w = 8'($urandom);
        m = model(4'h2, 8'h18, w, 3'h0);
        core.issue(4'h2, 7'h03, 1'b1, w);
        #1;
        check("flags", {m[10:8], 2'b11, m[2:0]}, core_flags);
        wr(7'h03, 8'h00);
        fl = 3'h0;
        for (int i = 0; i < 40; i++) begin
            op = i < 2 ? 4'(i + 2) : 4'($urandom_range(5, 2));
            v = i < 2 ? 8'h0f : 8'($urandom);
            w = i == 0 ? 8'h01 : i == 1 ? 8'h0f : 8'($urandom);
            m = model(op, v, w, fl);
            fl = m[2:0];
            wr(7'h30, v);
            core.issue(op, 7'h30, 1'b0, w);
            #1;
            check("result", m[10:3], result_data);
            check("flags", {5'h03, fl}, core_flags);
        end
        core.issue(4'h6, 7'h03, 1'b1, 8'h00);
        #1;
        check("flags", {5'h03, 1'b1, fl[1:0]}, core_flags);
        @(posedge clock);
        port_a_in <= 6'h15;
        rd(7'h05, 8'h15);
        port_a_in <= 6'h2a;
        repeat (3) @(posedge clock);
        check("change", 8'h01, {7'h00, port_change_flag});
        foreach (evt[i]) begin
            @(posedge clock);
            ev <= evt[i][7:2];
            @(posedge clock);
            ev <= 6'h00;
            #1;
            check("expiry sleep", 8'(evt[i][1:0]), 8'(core_flags[4:3]));
            if (i == 4) check("change", 8'h01, {7'h00, port_change_flag});
        end
        final_report();
    end
endmodule : test_banked_data_memory_status
`default_nettype wire
